// file: rtl/srs_pkg.sv
// Constants, register map and types of the switch reset sequencer
package srs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int POR_TIME_US = 23000;
  localparam int PIN_TIME_US = 760;
  localparam int DIG_TIME_US = 760;
  localparam int SER_TIME_US = 10;
  localparam int PHY_TIME_US = 110;
  localparam int VPHY_TIME_US = 1;
  localparam int POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int PIN_CYC = PIN_TIME_US * CLK_MHZ;
  localparam int DIG_CYC = DIG_TIME_US * CLK_MHZ;
  localparam int SER_CYC = SER_TIME_US * CLK_MHZ;
  localparam int PHY_CYC = PHY_TIME_US * CLK_MHZ;
  localparam int VPHY_CYC = VPHY_TIME_US * CLK_MHZ;
  localparam int TW = 21;
  localparam int PW = 13;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int AW = 8;
  localparam logic [7:0] BYTE_TEST_OFS = 8'h00;
  localparam logic [7:0] HARDWARE_CONFIG_REG_OFS = 8'h04;
  localparam logic [7:0] RESET_CONTROL_REG_OFS = 8'h08;
  localparam logic [31:0] BYTE_TEST_VAL = 32'h8765_4321;
  localparam logic [31:0] BYTE_TEST_BAD = 32'h0000_0000;
  localparam int READY_POS = 0;
  localparam int PRES_LSB = 8;
  localparam int STRAP_LSB = 16;
  localparam int GEN_LSB = 24;
  localparam logic [7:0] PRES_RST = 8'h00;
  localparam logic [7:0] GEN_RST = 8'h00;
  localparam logic [7:0] STRAP_RST = 8'h00;
  localparam int DIGITAL_RESET_BIT = 0;
  localparam int PORT1_PHY_RESET_BIT = 1;
  localparam int PORT2_PHY_RESET_BIT = 2;
  localparam int VIRTUAL_PHY_RESET_BIT = 3;

  // ----------------------------------------
  // Sub-module reset indices
  // ----------------------------------------
  localparam int NMOD = 8;
  localparam int M_CLK = 0;
  localparam int M_IRQ = 1;
  localparam int M_FAB = 2;
  localparam int M_PMI = 3;
  localparam int M_I2C = 4;
  localparam int M_SMI = 5;
  localparam int M_EEP = 6;
  localparam int M_GPIO = 7;
  localparam logic [NMOD-1:0] SER_MASK = 8'h30;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_SER = 3'b001,
    ST_BASE = 3'b010,
    ST_LOAD = 3'b011,
    ST_READY = 3'b100
  } srs_state_e;

  typedef enum logic [1:0] {
    K_POR = 2'b00,
    K_PIN = 2'b01,
    K_DIG = 2'b10
  } srs_kind_e;

endpackage : srs_pkg

// file: rtl/srs_switch_reset_sequencer.sv
// Reset and configuration sequencer of a three-port managed switch
// Operation
// - Sub-system clocks come from 50 MHz base
// - Chip reset asserts all, latches straps, loads
// - Low external reset pin starts chip reset
// - Straps captured once all chip resets release
// - Loader runs after power-on, pin, digital reset
// - Digital reset spares PHYs, resets other modules
// - Writing digital-reset bit starts multi-module reset
// - Multi-module reset never re-latches straps
// - Preserved bits survive a digital reset
// - Byte probe invalid until serial resets finish
// - Ready flag set only after whole reset
// - Power-on reset lasts about 23 ms
// - Pin reset lasts about 760 us
// - Digital reset lasts about 760 us
// - PHY reset touches only that PHY
// - Port PHY bit self-clears after 110 us
// - Virtual PHY bit self-clears after 1 us
`timescale 1ns/1ns

module srs_switch_reset_sequencer
  import srs_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int PIN_CYCLES = PIN_CYC,
  parameter int DIG_CYCLES = DIG_CYC,
  parameter int PHY_CYCLES = PHY_CYC
) (
  input wire logic clk_in,
  input wire logic ext_reset_in_n_in,
  input wire logic ext_reset_in_n,
  input wire logic pll_lock_in,
  input wire logic [7:0] strap_in,
  input wire logic eeprom_done_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  output logic sysclk_rst_n_out,
  output logic irq_rst_n_out,
  output logic fabric_rst_n_out,
  output logic pmi_rst_n_out,
  output logic i2c_rst_n_out,
  output logic smi_rst_n_out,
  output logic eeprom_rst_n_out,
  output logic gpio_rst_n_out,
  output logic port1_phy_rst_n_out,
  output logic port2_phy_rst_n_out,
  output logic virtual_phy_reset_bit_n_out,
  output logic [7:0] strap_out,
  output logic eeprom_start_out,
  output logic device_ready_out
);

  // ----------------------------------------
  // Timing helpers
  // ----------------------------------------
  function automatic logic [TW-1:0] base_last(input srs_kind_e k);
    int c;
    case (k)
      K_POR: c = POR_CYCLES;
      K_PIN: c = PIN_CYCLES;
      K_DIG: c = DIG_CYCLES;
      default: c = DIG_CYCLES;
    endcase
    if (c < 2) begin
      c = 2;
    end
    return TW'(c - 1);
  endfunction : base_last

  function automatic logic [PW-1:0] phy_last(input int idx);
    int c;
    c = (idx == 2) ? VPHY_CYC : PHY_CYCLES;
    if (c < 1) begin
      c = 1;
    end
    return PW'(c - 1);
  endfunction : phy_last

  // ----------------------------------------
  // Chip reset merge and input synchronisers
  // ----------------------------------------
  // The pin pulls every reset down at once, without the clock; release
  // waits two edges so that all domains leave reset on the same edge.
  logic chip_arst_n, chip_rst_n;
  logic [1:0] chip_sync_q, lock_sync_q;
  logic [7:0] strap_m_q, strap_s_q;
  assign chip_arst_n = ext_reset_in_n_in & ext_reset_in_n;
  assign chip_rst_n = chip_sync_q[1];
  always_ff @(posedge clk_in or negedge chip_arst_n) begin
    if (!chip_arst_n) begin
      chip_sync_q <= 2'h0;
    end else begin
      chip_sync_q <= {chip_sync_q[0], 1'b1};
    end
  end

  always_ff @(posedge clk_in or negedge ext_reset_in_n_in) begin
    if (!ext_reset_in_n_in) begin
      lock_sync_q <= 2'h0;
      strap_m_q <= 8'h00;
      strap_s_q <= 8'h00;
    end else begin
      lock_sync_q <= {lock_sync_q[0], pll_lock_in};
      strap_m_q <= strap_in;
      strap_s_q <= strap_m_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [31:0] rd_data_d, rd_data_q;
  logic [7:0] pres_d, pres_q, gen_d, gen_q;
  logic dig_req;
  logic [2:0] phy_req;
  srs_state_e state_d, state_q;
  srs_kind_e kind_d, kind_q;
  logic [TW-1:0] timer_d, timer_q;
  logic [NMOD-1:0] mod_rst_n_d, mod_rst_n_q;
  logic [7:0] strap_d, strap_q;
  logic ser_ok_d, ser_ok_q, ready_d, ready_q;
  logic start_d, start_q, por_seen_d, por_seen_q;
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    timer_d = timer_q;
    mod_rst_n_d = mod_rst_n_q;
    strap_d = strap_q;
    ser_ok_d = ser_ok_q;
    ready_d = ready_q;
    start_d = 1'b0;
    por_seen_d = por_seen_q;
    case (state_q)
      ST_HOLD: begin
        // Apart from the PHY resets, nothing is timed until the base clock is stable
        if (lock_sync_q[1]) begin
          strap_d = strap_s_q;
          kind_d = por_seen_q ? K_PIN : K_POR;
          por_seen_d = 1'b1;
          timer_d = '0;
          state_d = ST_SER;
        end
      end
      ST_SER: begin
        timer_d = timer_q + TW'(1);
        if (timer_q == TW'(SER_CYC - 1)) begin
          mod_rst_n_d = mod_rst_n_q | SER_MASK;
          ser_ok_d = 1'b1;
          state_d = ST_BASE;
        end
      end
      ST_BASE: begin
        timer_d = timer_q + TW'(1);
        if (timer_q >= base_last(kind_q)) begin
          mod_rst_n_d = '1;
          start_d = 1'b1;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (eeprom_done_in && !start_q) begin
          ready_d = 1'b1;
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (dig_req) begin
          // PHY resets are left alone; straps keep their last latch
          mod_rst_n_d = '0;
          kind_d = K_DIG;
          ser_ok_d = 1'b0;
          ready_d = 1'b0;
          timer_d = '0;
          state_d = ST_SER;
        end
      end
      default: state_d = ST_HOLD;
    endcase
  end
  always_ff @(posedge clk_in or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      state_q <= ST_HOLD;
      kind_q <= K_POR;
      timer_q <= '0;
      mod_rst_n_q <= '0;
      strap_q <= STRAP_RST;
      ser_ok_q <= 1'b0;
      ready_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      timer_q <= timer_d;
      mod_rst_n_q <= mod_rst_n_d;
      strap_q <= strap_d;
      ser_ok_q <= ser_ok_d;
      ready_q <= ready_d;
      start_q <= start_d;
    end
  end

  // Only power loss forgets that a power-on sequence already ran
  always_ff @(posedge clk_in or negedge ext_reset_in_n_in) begin
    if (!ext_reset_in_n_in) begin
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= por_seen_d;
    end
  end

  // ----------------------------------------
  // Single-module PHY resets
  // ----------------------------------------
  logic [2:0] phy_rst_n_d, phy_rst_n_q;
  logic [PW-1:0] phy_cnt_d [3], phy_cnt_q [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      phy_rst_n_d[i] = phy_rst_n_q[i];
      phy_cnt_d[i] = phy_cnt_q[i];
      if (!phy_rst_n_q[i]) begin
        phy_cnt_d[i] = phy_cnt_q[i] + PW'(1);
        if (phy_cnt_q[i] >= phy_last(i)) begin
          phy_rst_n_d[i] = 1'b1;
        end
      end else if (phy_req[i]) begin
        phy_rst_n_d[i] = 1'b0;
        phy_cnt_d[i] = '0;
      end
    end
  end
  // A chip reset also holds the PHYs, then lets them time out
  always_ff @(posedge clk_in or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      phy_rst_n_q <= 3'h0;
      phy_cnt_q <= '{default: '0};
    end else begin
      phy_rst_n_q <= phy_rst_n_d;
      phy_cnt_q <= phy_cnt_d;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Writes are dropped until ready, so a host that breaks the rule
  // cannot disturb a sequence in progress.
  always_comb begin
    rd_data_d = 32'h0000_0000;
    pres_d = pres_q;
    gen_d = gen_q;
    dig_req = 1'b0;
    phy_req = 3'h0;
    if (wr_in && ready_q) begin
      case (addr_in)
        HARDWARE_CONFIG_REG_OFS: begin
          pres_d = wr_data_in[PRES_LSB +: 8];
          gen_d = wr_data_in[GEN_LSB +: 8];
        end
        RESET_CONTROL_REG_OFS: begin
          dig_req = wr_data_in[DIGITAL_RESET_BIT];
          phy_req = {wr_data_in[VIRTUAL_PHY_RESET_BIT],
                     wr_data_in[PORT2_PHY_RESET_BIT],
                     wr_data_in[PORT1_PHY_RESET_BIT]};
        end
        default: gen_d = gen_q;
      endcase
    end
    if (dig_req) begin
      gen_d = GEN_RST;
    end
    if (rd_in) begin
      case (addr_in)
        BYTE_TEST_OFS: rd_data_d = ser_ok_q ? BYTE_TEST_VAL : BYTE_TEST_BAD;
        HARDWARE_CONFIG_REG_OFS: begin
          rd_data_d[READY_POS] = ready_q;
          rd_data_d[PRES_LSB +: 8] = pres_q;
          rd_data_d[STRAP_LSB +: 8] = strap_q;
          rd_data_d[GEN_LSB +: 8] = gen_q;
        end
        RESET_CONTROL_REG_OFS: begin
          rd_data_d[DIGITAL_RESET_BIT] = (kind_q == K_DIG) && !ready_q;
          rd_data_d[PORT1_PHY_RESET_BIT] = !phy_rst_n_q[0];
          rd_data_d[PORT2_PHY_RESET_BIT] = !phy_rst_n_q[1];
          rd_data_d[VIRTUAL_PHY_RESET_BIT] = !phy_rst_n_q[2];
        end
        default: rd_data_d = 32'h0000_0000;
      endcase
    end
  end
  // The general field follows the block reset; the preserved one only
  // chip resets, which is what lets it survive a digital reset.
  always_ff @(posedge clk_in or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      rd_data_q <= 32'h0000_0000;
      pres_q <= PRES_RST;
      gen_q <= GEN_RST;
    end else begin
      rd_data_q <= rd_data_d;
      pres_q <= pres_d;
      gen_q <= gen_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data_out = rd_data_q;
  assign sysclk_rst_n_out = mod_rst_n_q[M_CLK];
  assign irq_rst_n_out = mod_rst_n_q[M_IRQ];
  assign fabric_rst_n_out = mod_rst_n_q[M_FAB];
  assign pmi_rst_n_out = mod_rst_n_q[M_PMI];
  assign i2c_rst_n_out = mod_rst_n_q[M_I2C];
  assign smi_rst_n_out = mod_rst_n_q[M_SMI];
  assign eeprom_rst_n_out = mod_rst_n_q[M_EEP];
  assign gpio_rst_n_out = mod_rst_n_q[M_GPIO];
  assign port1_phy_rst_n_out = phy_rst_n_q[0];
  assign port2_phy_rst_n_out = phy_rst_n_q[1];
  assign virtual_phy_reset_bit_n_out = phy_rst_n_q[2];
  assign strap_out = strap_q;
  assign eeprom_start_out = start_q;
  assign device_ready_out = ready_q;

endmodule : srs_switch_reset_sequencer

// file: verif/srs_checker.sv
// Port checker of the switch reset sequencer
`timescale 1ns/1ns
module srs_checker
  import srs_pkg::*;
#(
  parameter int PHY_CYCLES = PHY_CYC
) (
  input wire logic clk_in,
  input wire logic ext_reset_in_n_in,
  input wire logic ext_reset_in_n,
  input wire logic [AW-1:0] addr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic sysclk_rst_n_out,
  input wire logic fabric_rst_n_out,
  input wire logic gpio_rst_n_out,
  input wire logic smi_rst_n_out,
  input wire logic port1_phy_rst_n_out,
  input wire logic port2_phy_rst_n_out,
  input wire logic virtual_phy_reset_bit_n_out,
  input wire logic [7:0] strap_out,
  input wire logic eeprom_start_out,
  input wire logic device_ready_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!ext_reset_in_n_in || !ext_reset_in_n);
  localparam int VPHY_N = 50;
  // ----
  // Low-time counters; a shift chain would not hold these lengths
  // ----
  logic [15:0] p1_q;
  logic [15:0] vp_q;
  always_ff @(posedge clk_in or negedge ext_reset_in_n_in) begin
    if (!ext_reset_in_n_in) begin
      p1_q <= 16'h0;
      vp_q <= 16'h0;
    end else begin
      p1_q <= port1_phy_rst_n_out ? 16'h0 : p1_q + 16'h1;
      vp_q <= virtual_phy_reset_bit_n_out ? 16'h0 : vp_q + 16'h1;
    end
  end
  // ----
  // Properties
  // ----
  property p_pin_hold;
    @(posedge clk_in) disable iff (!ext_reset_in_n_in)
    !ext_reset_in_n |-> !sysclk_rst_n_out && !smi_rst_n_out && !port1_phy_rst_n_out && !device_ready_out;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin reset left outputs active");
  property p_start_rel;
    $rose(fabric_rst_n_out) |-> eeprom_start_out;
  endproperty
  a_start_rel: assert property (p_start_rel) else $error("loader not started at release");
  property p_start_one;
    eeprom_start_out |=> !eeprom_start_out;
  endproperty
  a_start_one: assert property (p_start_one) else $error("loader start longer than one cycle");
  property p_ready_late;
    $rose(device_ready_out) |-> $past(gpio_rst_n_out, 2) && sysclk_rst_n_out;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready before modules released");
  property p_ready_clr;
    !gpio_rst_n_out |-> !device_ready_out;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready while modules in reset");
  property p_dig_phy;
    $fell(fabric_rst_n_out) |-> $stable({port1_phy_rst_n_out, port2_phy_rst_n_out, virtual_phy_reset_bit_n_out});
  endproperty
  a_dig_phy: assert property (p_dig_phy) else $error("digital reset touched a phy");
  property p_strap;
    (device_ready_out || $fell(fabric_rst_n_out)) |-> $stable(strap_out);
  endproperty
  a_strap: assert property (p_strap) else $error("straps changed outside chip reset");
  property p_probe;
    $past(rd_in && addr_in == BYTE_TEST_OFS) |->
      rd_data_out == ($past(smi_rst_n_out) ? BYTE_TEST_VAL : BYTE_TEST_BAD);
  endproperty
  a_probe: assert property (p_probe) else $error("byte probe value wrong");
  property p_phy_len;
    $rose(port1_phy_rst_n_out) && device_ready_out |-> p1_q == PHY_CYCLES;
  endproperty
  a_phy_len: assert property (p_phy_len) else $error("port phy reset length wrong");
  property p_vphy_len;
    $rose(virtual_phy_reset_bit_n_out) && device_ready_out |-> vp_q == VPHY_N;
  endproperty
  a_vphy_len: assert property (p_vphy_len) else $error("virtual phy reset length wrong");
  c_ready: cover property ($rose(device_ready_out));
  c_dig: cover property ($fell(fabric_rst_n_out));
  c_phy: cover property ($rose(port1_phy_rst_n_out) && device_ready_out);
endmodule : srs_checker

bind srs_switch_reset_sequencer srs_checker #(.PHY_CYCLES(PHY_CYCLES)) i_chk (
  .clk_in(clk_in), .ext_reset_in_n_in(ext_reset_in_n_in), .ext_reset_in_n(ext_reset_in_n), .addr_in(addr_in),
  .rd_in(rd_in), .rd_data_out(rd_data_out), .sysclk_rst_n_out(sysclk_rst_n_out),
  .fabric_rst_n_out(fabric_rst_n_out), .gpio_rst_n_out(gpio_rst_n_out), .smi_rst_n_out(smi_rst_n_out),
  .port1_phy_rst_n_out(port1_phy_rst_n_out), .port2_phy_rst_n_out(port2_phy_rst_n_out),
  .virtual_phy_reset_bit_n_out(virtual_phy_reset_bit_n_out), .strap_out(strap_out), .eeprom_start_out(eeprom_start_out),
  .device_ready_out(device_ready_out));

// file: verif/srs_loader_model.sv
// Loader stand-in answering a start pulse after a set delay
`timescale 1ns/1ns
module srs_loader_model (
  input wire logic clk_in,
  input wire logic ext_reset_in_n_in,
  input wire logic start_in,
  input wire logic rst_n_in,
  input wire logic [7:0] dly_in,
  output logic done_out
);
  logic busy_q;
  logic [7:0] cnt_q;
  // Done is a level that only the loader's own reset or the power-on reset takes down
  always_ff @(posedge clk_in or negedge ext_reset_in_n_in) begin
    if (!ext_reset_in_n_in) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      done_out <= 1'b0;
    end else if (!rst_n_in) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      done_out <= 1'b0;
    end else if (start_in) begin
      busy_q <= 1'b1;
      cnt_q <= dly_in;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'b0;
      done_out <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : srs_loader_model

// file: verif/testbench.sv
// Self-checking bench of the switch reset sequencer
`timescale 1ns/1ns
module testbench
  import srs_pkg::*;
;
  localparam int POR_C = 900;
  localparam int PIN_C = 600;
  localparam int DIG_C = 700;
  localparam int PHY_C = 100;
  logic clk_in = 1'b0;
  logic ext_reset_in_n_in = 1'b0;
  logic ext_reset_in_n = 1'b1;
  logic pll_lock_in = 1'b1;
  logic [7:0] strap_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_d = 1'b0;
  logic [AW-1:0] addr_in = '0;
  logic [31:0] wr_data_in = '0;
  logic [7:0] dly = 8'h05;
  logic [31:0] rd_data_out;
  logic [7:0] mods;
  logic [2:0] phys;
  logic [7:0] strap_out, s1, s2, pr, gn;
  logic eeprom_start_out, eeprom_done_in, device_ready_out;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0, n;
  // Free-running reference as the host must supply it
  initial forever #10 clk_in = ~clk_in;
  srs_switch_reset_sequencer #(.POR_CYCLES(POR_C), .PIN_CYCLES(PIN_C), .DIG_CYCLES(DIG_C),
    .PHY_CYCLES(PHY_C)) i_dut (
    .clk_in(clk_in), .ext_reset_in_n_in(ext_reset_in_n_in), .ext_reset_in_n(ext_reset_in_n), .pll_lock_in(pll_lock_in),
    .strap_in(strap_in), .eeprom_done_in(eeprom_done_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .sysclk_rst_n_out(mods[7]),
    .irq_rst_n_out(mods[6]), .fabric_rst_n_out(mods[5]), .pmi_rst_n_out(mods[4]), .i2c_rst_n_out(mods[3]),
    .smi_rst_n_out(mods[2]), .eeprom_rst_n_out(mods[1]), .gpio_rst_n_out(mods[0]),
    .port1_phy_rst_n_out(phys[2]), .port2_phy_rst_n_out(phys[1]), .virtual_phy_reset_bit_n_out(phys[0]),
    .strap_out(strap_out), .eeprom_start_out(eeprom_start_out), .device_ready_out(device_ready_out));
  srs_loader_model i_ldr (.clk_in(clk_in), .ext_reset_in_n_in(ext_reset_in_n_in), .start_in(eeprom_start_out),
    .rst_n_in(mods[1]), .dly_in(dly), .done_out(eeprom_done_in));
  // ----
  // Tasks
  // ----
  function automatic logic [31:0] hw(logic [7:0] g, logic [7:0] s, logic [7:0] p, logic r);
    return {g, s, p, 7'h00, r};
  endfunction : hw
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Called just after an edge; strobes stay up until the caller issues the next cycle
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    if (r) exp_q.push_back(e);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
  endtask : bus
  task automatic wait_hi(input logic sel, output int c);
    c = 0;
    do begin
      @(negedge clk_in);
      c++;
    end while ((sel ? eeprom_start_out : device_ready_out) !== 1'b1 && c < 9000);
    if (c >= 9000) begin
      n_errors++;
      summarize();
    end
    @(posedge clk_in);
  endtask : wait_hi
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  always @(posedge clk_in) rd_d <= rd_in;
  always @(negedge clk_in) begin
    cyc++;
    if (rd_d) chk(rd_data_out, exp_q.pop_front());
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    n = $urandom(23523);
    s1 = $urandom;
    s2 = $urandom;
    pr = $urandom;
    gn = $urandom;
    strap_in = s1;
    repeat (10) @(posedge clk_in);
    ext_reset_in_n_in <= 1'b1;
    dly <= 8'($urandom % 40);
    t0 = cyc;
    repeat (3) @(posedge clk_in);
    bus(1'b0, 1'b1, BYTE_TEST_OFS, 0, BYTE_TEST_BAD);
    bus(1'b1, 1'b0, HARDWARE_CONFIG_REG_OFS, 32'hffff_ffff, 0);
    bus(1'b0, 1'b0, 0, 0, 0);
    wait_hi(1'b1, n);
    chk(32'(cyc - t0 >= POR_C && cyc - t0 <= POR_C + 12), 1);
    wait_hi(1'b0, n);
    chk({mods, strap_out}, {8'hff, s1});
    bus(1'b0, 1'b1, BYTE_TEST_OFS, 0, BYTE_TEST_VAL);
    bus(1'b0, 1'b1, HARDWARE_CONFIG_REG_OFS, 0, hw(GEN_RST, s1, PRES_RST, 1'b1));
    bus(1'b1, 1'b0, HARDWARE_CONFIG_REG_OFS, {gn, ~s1, pr, 8'hfe}, 0);
    bus(1'b0, 1'b1, HARDWARE_CONFIG_REG_OFS, 0, hw(gn, s1, pr, 1'b1));
    bus(1'b0, 1'b1, 8'h0c, 0, 0);
    $display("test por done");
    bus(1'b1, 1'b0, RESET_CONTROL_REG_OFS, 32'h2, 0);
    bus(1'b1, 1'b0, RESET_CONTROL_REG_OFS, 32'h8, 0);
    bus(1'b0, 1'b1, RESET_CONTROL_REG_OFS, 0, 32'ha);
    bus(1'b0, 1'b0, 0, 0, 0);
    chk({mods, phys, device_ready_out}, {8'hff, 3'b010, 1'b1});
    repeat (PHY_C) @(posedge clk_in);
    bus(1'b1, 1'b0, RESET_CONTROL_REG_OFS, 32'h4, 0);
    bus(1'b0, 1'b1, RESET_CONTROL_REG_OFS, 0, 32'h4);
    bus(1'b0, 1'b0, 0, 0, 0);
    chk({mods, phys}, {8'hff, 3'b101});
    repeat (PHY_C + 2) @(posedge clk_in);
    $display("test phy done");
    strap_in <= s2;
    dly <= 8'd200;
    t0 = cyc;
    bus(1'b1, 1'b0, RESET_CONTROL_REG_OFS, 32'h1, 0);
    bus(1'b0, 1'b0, 0, 0, 0);
    bus(1'b0, 1'b1, RESET_CONTROL_REG_OFS, 0, 32'h1);
    bus(1'b0, 1'b0, 0, 0, 0);
    chk({mods, phys, device_ready_out}, {8'h00, 3'b111, 1'b0});
    wait_hi(1'b1, n);
    chk(32'(cyc - t0 >= DIG_C && cyc - t0 <= DIG_C + 12), 1);
    wait_hi(1'b0, n);
    bus(1'b0, 1'b1, HARDWARE_CONFIG_REG_OFS, 0, hw(GEN_RST, s1, pr, 1'b1));
    bus(1'b0, 1'b0, 0, 0, 0);
    $display("test digital done");
    ext_reset_in_n <= 1'b0;
    pll_lock_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({mods, phys, device_ready_out}, 12'h000);
    ext_reset_in_n <= 1'b1;
    repeat (20) @(posedge clk_in);
    chk({mods, strap_out, device_ready_out}, 17'h00000);
    pll_lock_in <= 1'b1;
    t0 = cyc;
    wait_hi(1'b1, n);
    chk(32'(cyc - t0 >= PIN_C && cyc - t0 <= PIN_C + 12), 1);
    wait_hi(1'b0, n);
    chk({mods, strap_out}, {8'hff, s2});
    bus(1'b0, 1'b1, HARDWARE_CONFIG_REG_OFS, 0, hw(GEN_RST, s2, PRES_RST, 1'b1));
    bus(1'b0, 1'b0, 0, 0, 0);
    repeat (2) @(posedge clk_in);
    $display("test pin done");
    summarize();
  end
endmodule : testbench
